// File: hdl/ebcs_top.v
// External bus cycle sequencer with AXI4-Lite register access.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ebcs_map.vh"
module ebcs_top (
  input  wire        ref_clk,          // System clock, 200 MHz.
  input  wire        nrst,             // Synchronous reset, active low.
  input  wire [11:0] s_axi_awaddr,     // Write address.
  input  wire        s_axi_awvalid,    // Write address valid.
  output reg         s_axi_awready,    // Write address ready.
  input  wire [31:0] s_axi_wdata,      // Write data.
  input  wire [3:0]  s_axi_wstrb,      // Write strobes.
  input  wire        s_axi_wvalid,     // Write data valid.
  output reg         s_axi_wready,     // Write data ready.
  output reg  [1:0]  s_axi_bresp,      // Write response.
  output reg         s_axi_bvalid,     // Write response valid.
  input  wire        s_axi_bready,     // Write response ready.
  input  wire [11:0] s_axi_araddr,     // Read address.
  input  wire        s_axi_arvalid,    // Read address valid.
  output reg         s_axi_arready,    // Read address ready.
  output reg  [31:0] s_axi_rdata,      // Read data.
  output reg  [1:0]  s_axi_rresp,      // Read response.
  output reg         s_axi_rvalid,     // Read data valid.
  input  wire        s_axi_rready,     // Read data ready.
  output reg  [23:0] address_lines,    // Address pins.
  output reg  [15:0] shared_ad_out,    // Shared address/data lines, driven value.
  output reg         shared_ad_oe,     // Shared lines output enable.
  input  wire [15:0] shared_ad_in,     // Shared lines, sensed value.
  output reg  [15:0] data_out,         // Dedicated data lines, driven value.
  output reg         data_oe,          // Dedicated data lines output enable.
  input  wire [15:0] data_in,          // Dedicated data lines, sensed value.
  output reg         read_strobe_n,    // Read command, active low.
  output reg         write_strobe_n,   // Write command, active low.
  output reg         chip_select_n,    // Chip select, active low.
  output reg         upper_byte_enable_n, // Upper byte enable, active low.
  output reg         addr_latch_en,    // Address latch enable, active high.
  output reg         ready_in_sample,  // Pulses after active ready ends a wait state.
  input  wire        ready_pin,        // Ready handshake input.
  output reg         external_clock_output // Bus reference clock output.
);
  // ----------------------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_AB   = 7'h02;
  localparam [6:0] ST_C    = 7'h04;
  localparam [6:0] ST_D    = 7'h08;
  localparam [6:0] ST_E    = 7'h10;
  localparam [6:0] ST_RDY  = 7'h20;
  localparam [6:0] ST_F    = 7'h40;

  reg  [31:0] chip_select_timing_config;
  reg  [31:0] ctrl;
  reg  [23:0] req_addr;
  reg  [15:0] req_wdata;
  reg  [15:0] rd_data;
  reg         rd_done;
  reg  [6:0]  state;
  reg  [5:0]  cnt;
  reg         cur_write;
  reg  [23:0] cur_addr;
  reg  [15:0] cur_wdata;
  reg  [7:0]  last_window;
  reg         win_valid;
  reg         rdy_s1;
  reg         rdy_s2;
  reg         rdy_s3;
  reg         clk_phase;
  reg         aw_hold;
  reg         w_hold;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        cmd_push;
  wire        fifo_in_ready;
  wire [40:0] fifo_out;
  wire        fifo_out_valid;
  wire        fifo_take;
  wire        rdy_active;
  wire        do_write;

  // Returns one cycle count in bus timing units (one unit is one system clock).
  function [5:0] field2;
    input [31:0] cfg;
    input integer lsb;
    begin
      field2 = {4'h0, cfg[lsb+1], cfg[lsb]};
    end
  endfunction

  // ----------------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------------
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign cmd_push = do_write && (aw_addr == `EBCS_OFF_STATUS) && w_strb[0] &&
                    (w_data[`EBCS_CMD_READ] || w_data[`EBCS_CMD_WRITE]);

  always @(posedge ref_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      chip_select_timing_config <= `EBCS_TIMING_RST;
      ctrl          <= `EBCS_CTRL_RST;
      req_addr      <= 24'h00_0000;
      req_wdata     <= 16'h0000;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // A command write stalls in the slave while the request FIFO is full.
      if (do_write && (!cmd_push || fifo_in_ready)) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (aw_addr)
          `EBCS_OFF_TIMING: chip_select_timing_config <= w_data;
          `EBCS_OFF_CTRL:   ctrl <= w_data;
          `EBCS_OFF_ADDR:   req_addr <= w_data[23:0];
          `EBCS_OFF_WDATA:  req_wdata <= w_data[15:0];
          `EBCS_OFF_STATUS, `EBCS_OFF_RDATA: ;
          default:          s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `EBCS_OFF_TIMING: s_axi_rdata <= chip_select_timing_config;
          `EBCS_OFF_CTRL:   s_axi_rdata <= ctrl;
          `EBCS_OFF_ADDR:   s_axi_rdata <= {8'h00, req_addr};
          `EBCS_OFF_WDATA:  s_axi_rdata <= {16'h0000, req_wdata};
          `EBCS_OFF_RDATA:  s_axi_rdata <= {16'h0000, rd_data};
          `EBCS_OFF_STATUS: s_axi_rdata <= {24'h00_0000, fifo_out_valid, !fifo_in_ready,
                                            rd_done, 4'h0, state == ST_IDLE};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ebcs_fifo #(.WIDTH(41), .DEPTH(`EBCS_FIFO_DEPTH), .AW(`EBCS_FIFO_AW)) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_data   ({w_data[`EBCS_CMD_WRITE], req_addr, req_wdata}),
    .in_valid  (cmd_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take)
  );

  // ----------------------------------------------------------------------------
  // Ready input conditioning
  // ----------------------------------------------------------------------------
  // The extra stage in asynchronous mode adds one cycle of ready latency, so up to one more wait state.
  assign rdy_active = (ctrl[`EBCS_C_RDY_ASYNC] ? rdy_s3 : rdy_s2) == ctrl[`EBCS_C_RDY_POL];
  assign fifo_take  = (state == ST_IDLE) && fifo_out_valid;

  // ----------------------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt <= 6'h00;
      cur_write <= 1'b0;
      cur_addr <= 24'h00_0000;
      cur_wdata <= 16'h0000;
      last_window <= 8'h00;
      win_valid <= 1'b0;
      rd_data <= 16'h0000;
      rd_done <= 1'b0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
      clk_phase <= 1'b0;
      address_lines <= 24'h00_0000;
      shared_ad_out <= 16'h0000;
      shared_ad_oe <= 1'b0;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      chip_select_n <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      addr_latch_en <= 1'b0;
      ready_in_sample <= 1'b0;
      external_clock_output <= 1'b0;
    end else begin
      rdy_s1 <= ready_pin;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      clk_phase <= !clk_phase;
      // One toggle per edge here models a clock of two system periods, one unit high and one unit low.
      external_clock_output <= ctrl[`EBCS_C_CLK_EN] & !clk_phase;
      ready_in_sample <= (state == ST_RDY) && rdy_active;
      case (state)
        ST_IDLE: begin
          if (fifo_out_valid) begin
            cur_write <= fifo_out[40];
            cur_addr <= fifo_out[39:16];
            cur_wdata <= fifo_out[15:0];
            address_lines <= fifo_out[39:16];
            chip_select_n <= 1'b0;
            upper_byte_enable_n <= !ctrl[`EBCS_C_UBE];
            rd_done <= 1'b0;
            if (ctrl[`EBCS_C_MUX]) begin
              shared_ad_out <= fifo_out[31:16];
              shared_ad_oe <= 1'b1;
              addr_latch_en <= 1'b1;
            end
            // Window change adds up to three setup units.
            cnt <= {5'h00, chip_select_timing_config[`EBCS_T_AB_LSB]} +
                   ((win_valid && last_window != fifo_out[39:32]) ?
                    field2(chip_select_timing_config, `EBCS_T_AWIN_LSB) : 6'h00);
            last_window <= fifo_out[39:32];
            win_valid <= 1'b1;
            state <= ST_AB;
          end
        end
        ST_AB: begin
          if (cnt == 6'h00) begin
            addr_latch_en <= 1'b0;
            cnt <= field2(chip_select_timing_config, `EBCS_T_C_LSB);
            state <= ST_C;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        ST_C: begin
          if (cnt == 6'h00) begin
            cnt <= {5'h00, chip_select_timing_config[`EBCS_T_D_LSB]};
            if (ctrl[`EBCS_C_MUX]) begin
              // Write data replaces the address, a read releases the lines.
              shared_ad_out <= cur_wdata;
              shared_ad_oe <= cur_write;
            end else if (cur_write) begin
              data_out <= cur_wdata;
              data_oe <= 1'b1;
            end
            state <= ST_D;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        ST_D: begin
          if (cnt == 6'h00) begin
            read_strobe_n <= cur_write;
            write_strobe_n <= !cur_write;
            cnt <= {1'b0, chip_select_timing_config[`EBCS_T_E_LSB+4:`EBCS_T_E_LSB]};
            state <= ST_E;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        ST_E, ST_RDY: begin
          if (cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
          end else if (ctrl[`EBCS_C_RDY_EN] && !rdy_active) begin
            state <= ST_RDY;
          end else begin
            // Capture and strobe release share this edge; partner holds data until then.
            if (!cur_write) begin
              rd_data <= ctrl[`EBCS_C_MUX] ? shared_ad_in : data_in;
              rd_done <= 1'b1;
            end
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            cnt <= field2(chip_select_timing_config, `EBCS_T_F_LSB);
            state <= ST_F;
          end
        end
        ST_F: begin
          if (cnt == 6'h00) begin
            chip_select_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            shared_ad_oe <= 1'b0;
            data_oe <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hdl/ebcs_map.vh
// Register offsets, field positions, reset values and request FIFO size of the external bus cycle sequencer.
`ifndef EBCS_MAP_VH
`define EBCS_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define EBCS_OFF_TIMING   12'h000
`define EBCS_OFF_CTRL     12'h004
`define EBCS_OFF_ADDR     12'h008
`define EBCS_OFF_WDATA    12'h00c
`define EBCS_OFF_RDATA    12'h010
`define EBCS_OFF_STATUS   12'h014
// ----------------------------------------------------------------------------
// Timing register fields
// ----------------------------------------------------------------------------
`define EBCS_T_AB_LSB     0
`define EBCS_T_AB_W       1
`define EBCS_T_AWIN_LSB   2
`define EBCS_T_AWIN_W     2
`define EBCS_T_C_LSB      4
`define EBCS_T_C_W        2
`define EBCS_T_D_LSB      6
`define EBCS_T_E_LSB      8
`define EBCS_T_E_W        5
`define EBCS_T_F_LSB      13
`define EBCS_T_F_W        2
`define EBCS_TIMING_RST   32'h0000_0000
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define EBCS_C_MUX        0
`define EBCS_C_RDY_EN     1
`define EBCS_C_RDY_POL    2
`define EBCS_C_RDY_ASYNC  3
`define EBCS_C_CLK_EN     4
`define EBCS_C_UBE        5
`define EBCS_CTRL_RST     32'h0000_0000
// ----------------------------------------------------------------------------
// Command bits written to the status offset, and request FIFO size
// ----------------------------------------------------------------------------
`define EBCS_CMD_READ     0
`define EBCS_CMD_WRITE    1
`define EBCS_FIFO_DEPTH   16
`define EBCS_FIFO_AW      4
`endif

// File: hdl/ebcs_fifo.v
// Synchronous FIFO holding queued bus access requests.
`timescale 1ns/1ps
`default_nettype none
module ebcs_fifo #(
  parameter WIDTH = 41,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk, // System clock.
  input  wire             nrst,    // Synchronous reset, active low.
  input  wire [WIDTH-1:0] in_data, // Write side data.
  input  wire             in_valid,// Write side valid.
  output wire             in_ready,// Not full.
  output reg  [WIDTH-1:0] out_data,// Registered head word.
  output reg              out_valid,// Head word present.
  input  wire             out_ready // Consumer takes head.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  wire            load;

  assign in_ready = (count != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  assign load     = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign pop      = load;

  // Entries move into the registered head one at a time; count covers storage only.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_ptr];
        rd_ptr   <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// File: tb/ebcs_chk_asserts.sv
// Pin-level assertion checker of the external bus cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module ebcs_chk (
  input wire logic ref_clk,              // Clock.
  input wire logic nrst,                 // Reset.
  input wire logic shared_ad_oe,         // Shared lines enable.
  input wire logic data_oe,              // Data lines enable.
  input wire logic read_strobe_n,        // Read command.
  input wire logic write_strobe_n,       // Write command.
  input wire logic chip_select_n,        // Chip select.
  input wire logic addr_latch_en,        // Latch enable.
  input wire logic external_clock_output // Reference clock.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ale; addr_latch_en |-> !chip_select_n && read_strobe_n && write_strobe_n; endproperty
  a_ale: assert property (p_ale) else $error("latch enable outside setup");
  property p_cmd_cs; !(read_strobe_n && write_strobe_n) |-> !chip_select_n; endproperty
  a_cmd_cs: assert property (p_cmd_cs) else $error("strobe without select");
  property p_one_cmd; read_strobe_n || write_strobe_n; endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("both strobes low");
  property p_rd_float; !read_strobe_n |-> !data_oe && !shared_ad_oe; endproperty
  a_rd_float: assert property (p_rd_float) else $error("lines driven in read");
  property p_wr_drive; !write_strobe_n |-> data_oe || shared_ad_oe; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
  property p_hold; $rose(read_strobe_n) || $rose(write_strobe_n) |-> !chip_select_n; endproperty
  a_hold: assert property (p_hold) else $error("select ends with strobe");
  property p_setup; $fell(chip_select_n) |-> (read_strobe_n && write_strobe_n) [*2]; endproperty
  a_setup: assert property (p_setup) else $error("strobe too early");
  property p_refclk; external_clock_output |=> !external_clock_output; endproperty
  a_refclk: assert property (p_refclk) else $error("reference clock stuck");
  c_rd: cover property ($rose(read_strobe_n));
  c_wr: cover property ($rose(write_strobe_n));
  c_ale: cover property (addr_latch_en ##1 !addr_latch_en);
endmodule
bind ebcs_top ebcs_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .shared_ad_oe(shared_ad_oe), .data_oe(data_oe),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
  .addr_latch_en(addr_latch_en), .external_clock_output(external_clock_output));
`default_nettype wire

// File: tb/ebcs_mem.sv
// Behavioural model of a 16-bit memory on the external bus.
`timescale 1ns/1ps
`default_nettype none
module ebcs_mem #(
  parameter int DLY = 36
) (
  input  wire logic        ref_clk,        // Clock.
  input  wire logic        shared,         // Shared bus mode.
  input  wire logic        rdy_pol,        // Active ready level.
  input  wire logic [23:0] address_lines,  // Address.
  input  wire logic [15:0] shared_ad_out,  // Shared lines level.
  input  wire logic [15:0] data_out,       // Data lines level.
  input  wire logic        read_strobe_n,  // Read command.
  input  wire logic        write_strobe_n, // Write command.
  input  wire logic        chip_select_n,  // Select.
  input  wire logic        addr_latch_en,  // Latch enable.
  output logic      [15:0] shared_ad_in,   // Shared lines drive.
  output logic      [15:0] data_in,        // Data lines drive.
  output logic             ready_pin       // Ready.
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q = 16'h0;
  logic [7:0]  lat_a = 8'h0;
  logic [5:0]  wcnt = 6'h0;
  wire logic [7:0] idx = shared ? lat_a : address_lines[7:0];
  wire logic       rd = !read_strobe_n && !chip_select_n;
  wire logic       cmd = !(read_strobe_n && write_strobe_n) && !chip_select_n;
  // Released lines flip so a late capture cannot match by chance.
  assign data_in      = (rd && !shared) ? mem[idx] : ~last_q;
  assign shared_ad_in = (rd && shared) ? mem[idx] : ~last_q;
  assign ready_pin    = (cmd && wcnt >= DLY) ? rdy_pol : !rdy_pol;
  always @(posedge ref_clk) begin
    wcnt <= cmd ? wcnt + 6'h1 : 6'h0;
    if (addr_latch_en) lat_a <= shared_ad_out[7:0];
    if (rd) last_q <= mem[idx];
    if (cmd && !write_strobe_n) mem[idx] <= shared ? shared_ad_out : data_out;
  end
endmodule
`default_nettype wire

// File: tb/ebcs_top_tb.sv
// Self-checking testbench of the external bus cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "ebcs_map.vh"
module ebcs_top_tb;
  typedef struct packed {logic c; logic [1:0] r; logic [31:0] d;} ebcs_rx_t;
  typedef struct packed {logic [23:0] a; logic sh; logic rdy; logic [7:0] pre; logic [7:0] low; logic [7:0] post;} ebcs_bx_t;
  logic        clk, nrst, awv, wv, bry, arv, rry, shared, rpol, first;
  logic [11:0] awa, ara;
  logic [31:0] wd, tim, ctl, v;
  logic [23:0] a;
  logic [15:0] d;
  logic [7:0]  kb, win;
  wire logic   awr, wr_, bv, arr, rv, ale, aoe, doe, rdn, wrn, csn, xclk, rdy, ube, ris;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [23:0] addr;
  wire logic [15:0] ad_o, ad_i, m_ad, d_o, d_i, m_d;
  int          n_mismatch = 0, num_checks = 0, seed = 53, k, n_pre = 0, n_low = 0, n_post = 0, n_ale = 0, n_ris = 0;
  logic        cs_q;
  ebcs_rx_t    rq[$], re;
  ebcs_bx_t    xq[$], be;
  logic [1:0]  bq[$];
  assign ad_i = aoe ? ad_o : m_ad;
  assign d_i  = doe ? d_o : m_d;
  ebcs_top uut (.ref_clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .address_lines(addr),
    .shared_ad_out(ad_o), .shared_ad_oe(aoe), .shared_ad_in(ad_i), .data_out(d_o), .data_oe(doe), .data_in(d_i),
    .read_strobe_n(rdn), .write_strobe_n(wrn), .chip_select_n(csn), .upper_byte_enable_n(ube), .addr_latch_en(ale),
    .ready_in_sample(ris), .ready_pin(rdy), .external_clock_output(xclk));
  ebcs_mem u_mem (.ref_clk(clk), .shared(shared), .rdy_pol(rpol), .address_lines(addr), .shared_ad_out(ad_i),
    .data_out(d_i), .read_strobe_n(rdn), .write_strobe_n(wrn), .chip_select_n(csn), .addr_latch_en(ale),
    .shared_ad_in(m_ad), .data_in(m_d), .ready_pin(rdy));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int i;
    bit ta = 0, tw = 0;
    bq.push_back(er);
    @(posedge clk);
    awa <= ad;
    wd <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (i = 0; i < 400 && !(ta && tw); i++) begin
      @(posedge clk);
      if (awr === 1'b1 && !ta) begin ta = 1; awv <= 1'b0; end
      if (wr_ === 1'b1 && !tw) begin tw = 1; wv <= 1'b0; end
    end
    for (i = 0; i < 400 && bv !== 1'b1; i++) @(posedge clk);
    if (bv !== 1'b1) begin n_mismatch++; conclude(); end
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic c, input logic [1:0] er, input logic [31:0] ed,
                    output logic [31:0] q);
    int i;
    rq.push_back({c, er, ed});
    @(posedge clk);
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    for (i = 0; i < 400 && arr !== 1'b1; i++) @(posedge clk);
    arv <= 1'b0;
    for (i = 0; i < 400 && rv !== 1'b1; i++) @(posedge clk);
    if (rv !== 1'b1) begin n_mismatch++; conclude(); end
    q = rdata;
    rry <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    int i;
    for (i = 0; i < 1000; i++) begin rd(`EBCS_OFF_STATUS, 1'b0, 2'b00, 32'h0, q); if (q[0] && !q[7]) break; end
    if (!(q[0] && !q[7])) begin n_mismatch++; conclude(); end
  endtask
  task automatic issue(input logic w);
    ebcs_bx_t e;
    e.a = a;
    e.sh = ctl[`EBCS_C_MUX];
    e.rdy = ctl[`EBCS_C_RDY_EN];
    e.pre = 8'd3 + tim[0] + tim[5:4] + tim[6] + ((first || a[23:16] == win) ? 8'd0 : {6'd0, tim[3:2]});
    e.low = {3'd0, tim[12:8]} + 8'd1;
    e.post = {6'd0, tim[14:13]} + 8'd1;
    first = 1'b0;
    win = a[23:16];
    xq.push_back(e);
    wr(`EBCS_OFF_STATUS, 32'h1 << (w ? `EBCS_CMD_WRITE : `EBCS_CMD_READ), 2'b00);
  endtask
  always @(posedge clk) begin
    if (rv === 1'b1 && rry) begin
      re = rq.pop_front();
      if (re.c) chk({rresp, rdata}, {re.r, re.d});
    end
    if (bv === 1'b1 && bry) chk(bresp, bq.pop_front());
  end
  // Counts sampled cycles of each phase and judges the access when select ends.
  always @(posedge clk) begin
    cs_q <= csn;
    if (nrst && csn === 1'b0) begin
      if (!(rdn && wrn)) n_low++;
      else if (n_low == 0) n_pre++;
      else n_post++;
      if (ale) n_ale++;
      if (ris === 1'b1) n_ris++;
      if (ale) chk(ad_o, xq[0].a[15:0]);
      if (!(rdn && wrn)) chk(ube, !ctl[`EBCS_C_UBE]);
      if (!wrn) chk(ctl[`EBCS_C_MUX] ? ad_o : d_o, d);
    end else if (nrst && cs_q === 1'b0) begin
      be = xq.pop_front();
      chk(n_pre, be.pre);
      chk(be.rdy ? (n_low > be.low) : n_low, be.rdy ? 1 : be.low);
      chk(n_post, be.post);
      chk(n_ale > 0, be.sh);
      chk(n_ris, be.rdy);
      n_ris = 0;
      n_pre = 0;
      n_low = 0;
      n_post = 0;
      n_ale = 0;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {nrst, awv, wv, bry, arv, rry, shared, awa, ara, wd, win, tim, ctl, a, d} = '0;
    first = 1'b1;
    rpol = 1'b1;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`EBCS_OFF_TIMING, 1'b1, 2'b00, `EBCS_TIMING_RST, v);
    rd(`EBCS_OFF_CTRL, 1'b1, 2'b00, `EBCS_CTRL_RST, v);
    rd(12'h020, 1'b1, 2'b10, 32'h0, v);
    wr(12'h020, 32'h1, 2'b10);
    for (k = 0; k < 8; k++) begin
      kb = k[7:0];
      tim = (k == 0) ? 32'h0 : (k == 7) ? 32'h7fff : $random(seed) & 32'h7fff;
      ctl = {26'h0, kb[2], kb[1], kb[0] ^ kb[2], kb[2], kb[1], kb[0]};
      shared <= kb[0];
      rpol <= kb[2];
      a = {kb, 8'($random(seed)), kb};
      d = 16'($random(seed));
      wr(`EBCS_OFF_TIMING, tim, 2'b00);
      wr(`EBCS_OFF_CTRL, ctl, 2'b00);
      rd(`EBCS_OFF_TIMING, 1'b1, 2'b00, tim, v);
      wr(`EBCS_OFF_ADDR, {8'h0, a}, 2'b00);
      wr(`EBCS_OFF_WDATA, {16'h0, d}, 2'b00);
      issue(1'b1);
      wait_idle();
      issue(1'b0);
      wait_idle();
      rd(`EBCS_OFF_RDATA, 1'b1, 2'b00, {16'h0, d}, v);
    end
    tim = 32'h0;
    ctl = 32'h6;
    shared <= 1'b0;
    rpol <= 1'b1;
    wr(`EBCS_OFF_TIMING, tim, 2'b00);
    wr(`EBCS_OFF_CTRL, ctl, 2'b00);
    // Enough commands to outrun the ready-stretched accesses, so the last one waits for room.
    for (k = 0; k < 24; k++) issue(1'b1);
    rd(`EBCS_OFF_STATUS, 1'b0, 2'b00, 32'h0, v);
    chk(v[6], 1'b1);
    wait_idle();
    conclude();
  end
endmodule
`default_nettype wire
